// File: hw/dual_counter_timer_control.sv
`timescale 1ns/1ps
`include "timer_cfg.svh"
module dual_counter_timer_control (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset,
  // Register access
  input  wire timer_pkg::sfr_req_s sfr_req,
  output logic [7:0]              sfr_rdata,
  // Vector acknowledges: t0, t1, ext0, ext1
  input  wire logic [3:0]         irq_ack,
  // Polarity and timer 2/3 settings from elsewhere
  input  wire logic               ext_irq0_polarity,
  input  wire logic               ext_irq1_polarity,
  input  wire logic               t2_split,
  input  wire logic               t3_split,
  input  wire logic               t2_external_clock_select,
  input  wire logic               t3_external_clock_select,
  // Pins
  input  wire logic               t0_count_pin,
  input  wire logic               t1_count_pin,
  input  wire logic               ext_irq0_input,
  input  wire logic               ext_irq1_input,
  input  wire logic               ext_osc_clk,
  // Requests: t0, t1, ext0, ext1
  output logic [3:0]              irq_req,
  output logic                    t1_overflow_pulse,
  // Timer 2/3 ticks: t2 low, t2 high, t3 low, t3 high
  output logic [3:0]              t23_tick
);
  import timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] s1_ff, s2_ff, s3_ff, nxt_s1, nxt_s2, nxt_s3;
  logic [4:0] fall, rise;
  logic [1:0] act, act_prev_ff, nxt_act_prev;

  // Pins pass two flip-flops; a third stage feeds the edge detectors.
  always_comb begin
    nxt_s1 = {ext_osc_clk, ext_irq1_input, ext_irq0_input,
              t1_count_pin, t0_count_pin};
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    nxt_act_prev = act;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_ff <= 5'h00;
      s2_ff <= 5'h00;
      s3_ff <= 5'h00;
      act_prev_ff <= 2'h0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      act_prev_ff <= nxt_act_prev;
    end
  end

  // Edges and active levels of the synchronised pins.
  assign fall = s3_ff & ~s2_ff; // R13
  assign rise = s2_ff & ~s3_ff;
  assign act = {s2_ff[3] == ext_irq1_polarity,
                s2_ff[2] == ext_irq0_polarity}; // R11

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] timer_control_status_ff, timer_mode_select_ff, timer_clock_control_ff, nxt_timer_control_status, nxt_timer_mode_select, nxt_timer_clock_control;
  logic [7:0] tl0_ff, th0_ff, tl1_ff, th1_ff;
  logic [7:0] nxt_tl0, nxt_th0, nxt_tl1, nxt_th1, rdata_ff, nxt_rdata;
  logic [5:0] presc_ff, nxt_presc, presc_lim;
  logic [3:0] d12_ff, nxt_d12, t23_ff, nxt_t23;
  logic [2:0] ext8_ff, nxt_ext8;
  logic       presc_tick, ext8_tick, d12_tick, pulse_ff, nxt_pulse;
  logic       split, t0_run, t0_tick, t1_run, t1_tick, th0_tick;
  logic       t0_ovf, t1_ovf, th0_ovf;
  mode_e      t0_mode, t1_mode;
  tstep_s     s0, s1;

  // One count step in the given mode.
  function automatic tstep_s step(mode_e m, logic [7:0] hi, logic [7:0] lo);
    tstep_s r;
    r.hi = hi;
    r.lo = lo;
    r.ovf = 1'b0;
    unique case (m)
      MODE_13: {r.ovf, r.hi, r.lo[4:0]} = {1'b0, hi, lo[4:0]} + 14'h1;
      MODE_16: {r.ovf, r.hi, r.lo} = {1'b0, hi, lo} + 17'h1;
      MODE_RELOAD: begin
        r.ovf = &lo;
        r.lo = r.ovf ? hi : lo + 8'h1;
      end
      MODE_SPLIT: {r.ovf, r.lo} = {1'b0, lo} + 9'h1; // R01 R23
    endcase
    return r;
  endfunction

  // Prescaler, fixed divide by 12 and synchronised external divide by 8.
  always_comb begin
    unique case (timer_clock_control_ff[1:0])
      2'h0: presc_lim = `LIM_DIV12; // R18
      2'h1: presc_lim = `LIM_DIV4;
      2'h2: presc_lim = `LIM_DIV48;
      2'h3: presc_lim = `LIM_DIV48;
    endcase
    ext8_tick = rise[4] && (ext8_ff == `LIM_EXT8); // R19
    nxt_ext8 = rise[4] ? ext8_ff + 3'h1 : ext8_ff;
    nxt_presc = (presc_ff >= presc_lim) ? 6'h00 : presc_ff + 6'h01;
    presc_tick = (timer_clock_control_ff[1:0] == 2'h3) ? ext8_tick
                                         : (presc_ff >= presc_lim); // R18
    d12_tick = (d12_ff == 4'(`LIM_DIV12));
    nxt_d12 = d12_tick ? 4'h0 : d12_ff + 4'h1;
    // Timers 2 and 3 take sysclk, or their own external-select source.
    nxt_t23[0] = timer_clock_control_ff[4] |
                 (t2_external_clock_select ? ext8_tick : d12_tick); // R21
    nxt_t23[1] = t2_split & (timer_clock_control_ff[5] |
                 (t2_external_clock_select ? ext8_tick : d12_tick)); // R20
    nxt_t23[2] = timer_clock_control_ff[6] |
                 (t3_external_clock_select ? ext8_tick : d12_tick); // R21
    nxt_t23[3] = t3_split & (timer_clock_control_ff[7] |
                 (t3_external_clock_select ? ext8_tick : d12_tick)); // R20
  end

  // Run, clock choice and counting of both timers.
  always_comb begin
    t0_mode = mode_e'(timer_mode_select_ff[1:0]); // R15
    t1_mode = mode_e'(timer_mode_select_ff[5:4]); // R14
    split = (t0_mode == MODE_SPLIT);
    t0_tick = timer_mode_select_ff[`CNT0_BIT] ? fall[0]
            : (timer_clock_control_ff[`CLK0_BIT] | presc_tick); // R02 R13 R17
    t0_run = timer_control_status_ff[`TR0_BIT] &
             (~timer_mode_select_ff[`T0_GATE_BIT] | act[0]); // R09 R12
    th0_tick = timer_clock_control_ff[`CLK0_BIT] | presc_tick; // R03
    t1_tick = (timer_mode_select_ff[`CNT1_BIT] & ~split) ? fall[1]
            : (timer_clock_control_ff[`CLK1_BIT] | presc_tick); // R05 R16
    t1_run = split ? (t1_mode != MODE_SPLIT) // R07
           : (timer_control_status_ff[`TR1_BIT] & (~timer_mode_select_ff[`T1_GATE_BIT] | act[1]) &
              (t1_mode != MODE_SPLIT)); // R09 R12 R14
    s0 = step(t0_mode, th0_ff, tl0_ff);
    s1 = step(t1_mode, th1_ff, tl1_ff);
    t0_ovf = t0_run & t0_tick & s0.ovf;
    t1_ovf = t1_run & t1_tick & s1.ovf;
    th0_ovf = split & timer_control_status_ff[`TR1_BIT] & th0_tick & (&th0_ff); // R04 R23
    nxt_tl0 = (t0_run & t0_tick) ? s0.lo : tl0_ff;
    nxt_th0 = (t0_run & t0_tick & ~split) ? s0.hi : th0_ff;
    if (split && timer_control_status_ff[`TR1_BIT] && th0_tick) begin
      nxt_th0 = th0_ff + 8'h01; // R01 R04
    end
    nxt_tl1 = (t1_run & t1_tick) ? s1.lo : tl1_ff;
    nxt_th1 = (t1_run & t1_tick) ? s1.hi : th1_ff;
    nxt_pulse = t1_ovf; // R06
    // A software write to a count register wins over counting.
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        `ADDR_TL0: nxt_tl0 = sfr_req.wdata;
        `ADDR_TH0: nxt_th0 = sfr_req.wdata;
        `ADDR_TL1: nxt_tl1 = sfr_req.wdata;
        `ADDR_TH1: nxt_th1 = sfr_req.wdata;
        default: ;
      endcase
    end
  end

  // Control registers and flags; a hardware set beats any clear.
  always_comb begin
    logic [7:0] base;
    base = (sfr_req.wr && sfr_req.addr == `ADDR_TIMER_CONTROL_STATUS) ? sfr_req.wdata
                                                       : timer_control_status_ff;
    nxt_timer_control_status = base;
    nxt_timer_control_status[`TF0_BIT] = t0_ovf | (base[`TF0_BIT] & ~irq_ack[0]); // R08 R02
    nxt_timer_control_status[`TF1_BIT] = (split ? th0_ovf : t1_ovf) |
                         (base[`TF1_BIT] & ~irq_ack[1]); // R04 R05 R08
    for (int i = 0; i < 2; i++) begin
      nxt_timer_control_status[2*i+1] = base[2*i] ? ((act[i] & ~act_prev_ff[i]) |
                        (base[2*i+1] & ~irq_ack[2+i])) : act[i]; // R10 R11
    end
    nxt_timer_mode_select = (sfr_req.wr && sfr_req.addr == `ADDR_TIMER_MODE_SELECT) ? sfr_req.wdata
                                                          : timer_mode_select_ff;
    nxt_timer_clock_control = (sfr_req.wr && sfr_req.addr == `ADDR_TIMER_CLOCK_CONTROL) ? sfr_req.wdata
                                                            : timer_clock_control_ff;
    nxt_rdata = rdata_ff;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        `ADDR_TIMER_CONTROL_STATUS:  nxt_rdata = timer_control_status_ff;
        `ADDR_TIMER_MODE_SELECT:  nxt_rdata = timer_mode_select_ff;
        `ADDR_TIMER_CLOCK_CONTROL: nxt_rdata = timer_clock_control_ff;
        `ADDR_TL0:   nxt_rdata = tl0_ff;
        `ADDR_TH0:   nxt_rdata = th0_ff;
        `ADDR_TL1:   nxt_rdata = tl1_ff;
        `ADDR_TH1:   nxt_rdata = th1_ff;
        default:     nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timer_control_status_ff <= `RST_BYTE;
      timer_mode_select_ff <= `RST_BYTE;
      timer_clock_control_ff <= `RST_BYTE;
      tl0_ff <= `RST_BYTE;
      th0_ff <= `RST_BYTE;
      tl1_ff <= `RST_BYTE;
      th1_ff <= `RST_BYTE;
      rdata_ff <= 8'h00;
      presc_ff <= 6'h00;
      d12_ff <= 4'h0;
      ext8_ff <= 3'h0;
      t23_ff <= 4'h0;
      pulse_ff <= 1'b0;
    end else begin
      timer_control_status_ff <= nxt_timer_control_status;
      timer_mode_select_ff <= nxt_timer_mode_select;
      timer_clock_control_ff <= nxt_timer_clock_control;
      tl0_ff <= nxt_tl0;
      th0_ff <= nxt_th0;
      tl1_ff <= nxt_tl1;
      th1_ff <= nxt_th1;
      rdata_ff <= nxt_rdata;
      presc_ff <= nxt_presc;
      d12_ff <= nxt_d12;
      ext8_ff <= nxt_ext8;
      t23_ff <= nxt_t23;
      pulse_ff <= nxt_pulse;
    end
  end

  // Outputs are flop bits.
  assign sfr_rdata = rdata_ff;
  assign irq_req = {timer_control_status_ff[3], timer_control_status_ff[1], timer_control_status_ff[`TF1_BIT],
                    timer_control_status_ff[`TF0_BIT]};
  assign t1_overflow_pulse = pulse_ff;
  assign t23_tick = t23_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_tf0_set: assert property (t0_ovf |=> timer_control_status_ff[`TF0_BIT]) // R08
    else $error("overflow did not set timer 0 flag");
  a_th0_sets_tf1: assert property (th0_ovf |=> timer_control_status_ff[`TF1_BIT]) // R04
    else $error("split high wrap did not set timer 1 flag");
  a_split_no_tf1: assert property (split && !th0_ovf && !timer_control_status_ff[7] &&
    !sfr_req.wr |=> !timer_control_status_ff[`TF1_BIT]) // R05
    else $error("timer 1 set its flag in split mode");
  a_t1_pulse_out: assert property (t1_ovf |=> t1_overflow_pulse) // R06
    else $error("timer 1 overflow pulse missing");
  a_t1_stop_mode3: assert property (timer_mode_select_ff[5:4] == 2'h3 && !sfr_req.wr
    |=> $stable(tl1_ff) && $stable(th1_ff)) // R07
    else $error("timer 1 counted in mode 3");
  a_gate_hold: assert property (timer_mode_select_ff[`T0_GATE_BIT] && !act[0] &&
    !split && !sfr_req.wr |=> $stable(tl0_ff)) // R12
    else $error("gated timer 0 counted while input inactive");
  a_presc_gap: assert property (presc_tick && timer_clock_control_ff[1:0] != 2'h3
    |=> (!presc_tick || timer_clock_control_ff[1:0] == 2'h3) [*3]) // R18
    else $error("prescaler ticked too soon");
  a_edge_ack: assert property (timer_control_status_ff[0] && irq_ack[2] &&
    !(act[0] && !act_prev_ff[0]) && !sfr_req.wr |=> !timer_control_status_ff[1]) // R10
    else $error("edge flag not cleared by vector");
  a_split_wrap: assert property (split && t0_run && t0_tick &&
    tl0_ff == 8'hff && !sfr_req.wr |=> tl0_ff == 8'h00) // R23
    else $error("split low half did not wrap to zero");

  c_split_both: cover property (split ##[1:300] th0_ovf);
  c_t1_split_pulse: cover property (split && t1_ovf);
  c_edge_irq: cover property (timer_control_status_ff[0] ##1 timer_control_status_ff[1]);
  c_ext8_tick: cover property (timer_clock_control_ff[1:0] == 2'h3 && presc_tick);
endmodule

// File: hw/timer_cfg.svh
// Behaviour
// R01 - Split mode makes timer 0 two 8-bit counters.
// R02 - Low half uses timer 0 run, select, gate, flag.
// R03 - High half is timer only, never the pin.
// R04 - High half runs on timer 1 run, sets flag 1.
// R05 - Split: timer 1 never counts pin or sets flag.
// R06 - Split: timer 1 overflow pulse still goes out.
// R07 - Split: timer 1 runs unless its mode is 3.
// R08 - Overflow flags set by hardware, cleared by software/vector.
// R09 - Run bits enable the timers when set.
// R10 - External flags: edge clears on vector, level follows.
// R11 - Type select: 0 level, 1 edge; polarity separate.
// R12 - Gate set needs run and active external input.
// R13 - Counter select: clock at 0, pin falls at 1.
// R14 - Timer 1 modes: 13-bit, 16-bit, reload, inactive.
// R15 - Timer 0 modes: 13-bit, 16-bit, reload, split.
// R16 - Timer 1 clock select: prescaled or system clock.
// R17 - Timer 0 clock select: prescaled or system clock.
// R18 - Prescaler: divide by 12, 4, 48, external/8.
// R19 - External clock synchronised before divide by eight.
// R20 - Timers 2/3 high selects apply only when split.
// R21 - Timers 2/3 low selects pick source or sysclk.
// R22 - Count pin holds two cycles, quarter rate max.
// R23 - Split halves wrap to zero, raising their flag.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define ADDR_TIMER_CONTROL_STATUS   8'h88
`define ADDR_TIMER_MODE_SELECT   8'h89
`define ADDR_TL0    8'h8a
`define ADDR_TL1    8'h8b
`define ADDR_TH0    8'h8c
`define ADDR_TH1    8'h8d
`define ADDR_TIMER_CLOCK_CONTROL  8'h8e
`define RST_BYTE    8'h00
`define TF1_BIT     7
`define TR1_BIT     6
`define TF0_BIT     5
`define TR0_BIT     4
`define T1_GATE_BIT   7
`define CNT1_BIT    6
`define T0_GATE_BIT   3
`define CNT0_BIT    2
`define CLK1_BIT    3
`define CLK0_BIT    2
`define LIM_DIV12   6'h0b
`define LIM_DIV4    6'h03
`define LIM_DIV48   6'h2f
`define LIM_EXT8    3'h7
`endif

// File: hw/timer_pkg.sv
package timer_pkg;
  // Register port request from the CPU side.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_s;
  // Timer operating modes in field order.
  typedef enum logic [1:0] {MODE_13, MODE_16, MODE_RELOAD, MODE_SPLIT} mode_e;
  // Result of one count step.
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } tstep_s;
endpackage

// File: test/test_dual_counter_timer_control.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module test_dual_counter_timer_control;
  import timer_pkg::*;
  // Stimulus, observed outputs and bookkeeping.
  logic               clk_sys = 1'b0;
  logic               reset = 1'b1;
  sfr_req_s           sfr_req = '0;
  logic [7:0]         sfr_rdata;
  logic [3:0]         irq_ack = '0;
  logic [1:0]         pol = 2'b11;
  logic [1:0]         inp = '0;
  logic [1:0]         split = '0;
  logic               pin0 = 1'b1;
  logic               osc = 1'b0;
  logic [2:0]         osc_cnt = '0;
  logic [3:0]         irq_req;
  logic               t1_ovf;
  logic [3:0]         t23_tick;
  logic [7:0]         d;
  logic [7:0]         d2;
  logic [7:0]         regs [4] = '{8'h88, 8'h89, 8'h8e, 8'h80};
  int                 div [4] = '{12, 4, 48, 64};
  int                 mismatches = 0;
  int                 n_checks = 0;
  int                 seed = 32'hf106c97e;
  int                 s0;
  int                 s1;
  int                 i;

  // System clock, and a slow oscillator of eight system cycles a period.
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    osc_cnt <= osc_cnt + 3'h1;
    osc     <= osc_cnt[2];
  end

  dual_counter_timer_control i_dual_counter_timer_control (
    .clk_sys(clk_sys), .reset(reset), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .irq_ack(irq_ack),
    .ext_irq0_polarity(pol[0]), .ext_irq1_polarity(pol[1]),
    .t2_split(split[0]), .t3_split(split[1]),
    .t2_external_clock_select(1'b0), .t3_external_clock_select(1'b0),
    .t0_count_pin(pin0), .t1_count_pin(pin0),
    .ext_irq0_input(inp[0]), .ext_irq1_input(inp[1]), .ext_osc_clk(osc),
    .irq_req(irq_req), .t1_overflow_pulse(t1_ovf), .t23_tick(t23_tick));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison helpers; the near form allows one tick of divider phase.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input logic [7:0] got, input int exp);
    n_checks++;
    if (^got === 1'bx || got + 1 < exp || got > exp + 1) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register writes and reads, each request held for one taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    sfr_req <= '{a, 1'b1, 1'b0, v};
    @(posedge clk_sys);
    sfr_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk_sys);
    sfr_req.rd <= 1'b0;
    @(negedge clk_sys);
    v = sfr_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // The whole sequence needs well under ten thousand cycles.
  initial begin
    #500000;
    mismatches++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset values, and an unmapped address that reads as zero.
    foreach (regs[k]) begin
      rd(regs[k], d);
      chk(d, 8'h00);
    end
    // Split mode: both halves start near the top and wrap within 42 steps.
    s0 = 8'he0 | ($random(seed) & 8'h1f);
    s1 = 8'he0 | ($random(seed) & 8'h1f);
    wr(8'h89, 8'h03);
    wr(8'h8e, 8'h04);
    wr(8'h8a, s0[7:0]);
    wr(8'h8c, s1[7:0]);
    wr(8'h88, 8'h50);
    cyc(38);
    chk({6'h0, irq_req[1:0]}, 8'h03);
    @(posedge clk_sys) irq_ack[0] <= 1'b1;
    @(posedge clk_sys) irq_ack[0] <= 1'b0;
    @(negedge clk_sys);
    chk({6'h0, irq_req[1:0]}, 8'h02);
    wr(8'h88, 8'h00);
    rd(8'h8a, d);
    chk(d, 8'(s0 + 42));
    rd(8'h8c, d);
    chk(d, 8'(s1 + 42));
    // Timer 1 beside split mode: pulses out, no flag, stops in mode 3.
    wr(8'h89, 8'h23);
    wr(8'h8e, 8'h08);
    wr(8'h8d, 8'hfe);
    wr(8'h8b, 8'hfe);
    i = 0;
    repeat (20) begin
      @(negedge clk_sys);
      if (t1_ovf === 1'b1)
        i++;
    end
    chk(8'(i > 0), 8'h01);
    chk({7'h0, irq_req[1]}, 8'h00);
    wr(8'h89, 8'h33);
    rd(8'h8b, d);
    cyc(5);
    rd(8'h8b, d2);
    chk(d2, d);
    // Counter function: five falls of the count pin.
    wr(8'h89, 8'h05);
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'h10);
    repeat (5) begin
      @(posedge clk_sys) pin0 <= 1'b0;
      repeat (4) @(posedge clk_sys);
      pin0 <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    cyc(6);
    rd(8'h8a, d);
    chk(d, 8'h05);
    // Gate: no counting while the input is inactive; level flags follow.
    wr(8'h89, 8'h09);
    wr(8'h8e, 8'h04);
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'h10);
    cyc(10);
    rd(8'h8a, d);
    chk(d, 8'h00);
    @(posedge clk_sys) inp <= 2'b11;
    cyc(8);
    chk({6'h0, irq_req[3:2]}, 8'h03);
    rd(8'h8a, d);
    chk(8'(d != 8'h00), 8'h01);
    @(posedge clk_sys) inp <= 2'b00;
    cyc(8);
    chk({6'h0, irq_req[3:2]}, 8'h00);
    // Edge mode, active low: the flag latches until the vector clears it.
    wr(8'h88, 8'h05);
    pol <= 2'b00;
    inp <= 2'b11;
    cyc(8);
    wr(8'h88, 8'h05);
    @(posedge clk_sys) inp <= 2'b00;
    cyc(8);
    chk({6'h0, irq_req[3:2]}, 8'h03);
    @(posedge clk_sys) inp <= 2'b11;
    cyc(8);
    chk({6'h0, irq_req[3:2]}, 8'h03);
    @(posedge clk_sys) irq_ack <= 4'hc;
    @(posedge clk_sys) irq_ack <= 4'h0;
    cyc(2);
    chk({6'h0, irq_req[3:2]}, 8'h00);
    // Every prescale setting over 130 steps.
    wr(8'h89, 8'h01);
    for (i = 0; i < 4; i++) begin
      wr(8'h8e, 8'(i));
      wr(8'h8a, 8'h00);
      wr(8'h88, 8'h10);
      cyc(128);
      wr(8'h88, 8'h00);
      rd(8'h8a, d);
      near(d, 130 / div[i]);
    end
    // Timer 2/3 ticks on system clock; high tick only when split.
    for (i = 0; i < 2; i++) begin
      wr(8'h8e, 8'h30 << (2 * i));
      cyc(4);
      chk({6'h0, t23_tick[2*i+1 -: 2]}, 8'h01);
      @(posedge clk_sys) split[i] <= 1'b1;
      cyc(4);
      chk({6'h0, t23_tick[2*i+1 -: 2]}, 8'h03);
    end
    summarize();
  end
endmodule
